/* design/wdf_watchdog.v */
`timescale 1ns/1ps
`include "wdf_defines.vh"

// How it works
// - Timer mode copies control register into active control on the next watchdog clock.
// - Reload value reaches down counter only by a completed feed or an underflow.
// - Control bits 7..5 hold tap_select choosing the prescaler tap.
// - Timeout equals 2^(5+tap) times (reload+1), plus one watchdog clock.
// - tap_select takes 0..7, reload value takes 0..255.
// - Timer mode moves control writes to shadow after one watchdog clock.
// - Timer mode underflow sets underflow_flag.
// - Timer mode underflow raises interrupt when irq enable is set.
// - Writing zero to underflow_flag clears it.
// - Timer mode underflow reloads counter from reload value and keeps counting.
// - Timer mode malformed feed does nothing.
// - In power down the oscillator runs only while it is the active or the target clock source.
// - Peripheral clock selected and power down halts the counter.
// - Dedicated 400KHz oscillator selectable instead of peripheral clock.
// - Clock source change applies only after a completed feed.
// - Switch waits two old clock ticks, then two new clock ticks.
// - Prescaler restarts after every completed feed.
// - Feed is A5 to first then 5A to second; no writes between.
// - Watchdog mode bad feed resets the device at once.
// - run_bit set starts the counter, cleared stops it.
// - clock_source_select 1 picks oscillator, 0 picks peripheral clock.
module wdf_watchdog #(
    parameter OSC_DIV  = `WDF_OSC_DIV,
    parameter PCLK_DIV = `WDF_PCLK_DIV
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Special function register bus
    input  wire [7:0] sfr_addr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_we,
    input  wire       sfr_re,
    output reg  [7:0] sfr_rdata,
    // Configuration and system
    input  wire       reset_enable_cfg,
    input  wire       watchdog_irq_enable,
    input  wire       power_down,
    // Results
    output reg        wdt_reset_out,
    output reg        wdt_irq,
    output reg        osc_running
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    localparam SW_IDLE = 2'd0;
    localparam SW_DROP = 2'd1;
    localparam SW_ADD  = 2'd2;

    // Reset image of the control register, split into its fields below
    localparam [7:0] CTRL_RST = `WDF_CTRL_RST;

    // Software-visible copies
    reg [2:0]              tap_select_r;
    reg                    run_bit_r;
    reg                    underflow_flag_r;
    reg                    clock_source_select_r;
    reg [7:0]              reload_value_r;
    reg [7:0]              rdata_nxt;

    // Active control and clock switch
    reg [2:0]              sh_tap_r;
    reg                    sh_run_r;
    reg                    pend_upd_r;
    reg                    act_sel_r;
    reg                    tgt_sel_r;
    reg [1:0]              sw_state_r;
    reg [1:0]              sw_cnt_r;
    reg                    feed_armed_r;

    // Counting
    reg [`WDF_PRESC_W-1:0] presc_r;
    reg [7:0]              count_r;
    reg                    expire_r;

    // Clock enables
    reg [7:0]              pdiv_r;
    reg [7:0]              odiv_r;
    reg                    pclk_tick_r;
    reg                    osc_tick_r;

    wire wr_ctrl   = sfr_we && (sfr_addr == `WDF_ADDR_CTRL);
    wire wr_reload = sfr_we && (sfr_addr == `WDF_ADDR_RELOAD);
    wire wr_feed1  = sfr_we && (sfr_addr == `WDF_ADDR_FEED1);
    wire wr_feed2  = sfr_we && (sfr_addr == `WDF_ADDR_FEED2);
    wire wd_mode   = reset_enable_cfg;

    // ----------------------------------------------------------------
    // Feed sequence decoding
    // ----------------------------------------------------------------
    // Reads never disturb the armed state; any other write does.
    // A repeated first write while armed keeps the sequence armed.
    wire feed_start = wr_feed1 && (sfr_wdata == `WDF_FEED1_CODE);
    wire feed_done  = feed_armed_r && wr_feed2
                      && (sfr_wdata == `WDF_FEED2_CODE);
    wire feed_bad   = sfr_we && !feed_done && !feed_start
                      && (feed_armed_r || wr_feed1 || wr_feed2);

    always @(posedge clk) begin
        if (rst) begin
            feed_armed_r <= 1'b0;
        end else if (sfr_we) begin
            feed_armed_r <= feed_start;
        end
    end

    // ----------------------------------------------------------------
    // Clock enables: peripheral clock and watchdog oscillator
    // ----------------------------------------------------------------
    // The oscillator stays awake while it is either side of a pending switch
    wire osc_on = !power_down || act_sel_r || tgt_sel_r;

    always @(posedge clk) begin
        if (rst) begin
            pdiv_r      <= 8'h00;
            odiv_r      <= 8'h00;
            pclk_tick_r <= 1'b0;
            osc_tick_r  <= 1'b0;
            osc_running <= 1'b1;
        end else begin
            osc_running <= osc_on;
            // Peripheral clock stops entirely in power down
            pclk_tick_r <= 1'b0;
            if (!power_down) begin
                if (pdiv_r == PCLK_DIV[7:0] - 8'h01) begin
                    pdiv_r      <= 8'h00;
                    pclk_tick_r <= 1'b1;
                end else begin
                    pdiv_r <= pdiv_r + 8'h01;
                end
            end
            osc_tick_r <= 1'b0;
            if (osc_on) begin
                if (odiv_r == OSC_DIV[7:0] - 8'h01) begin
                    odiv_r     <= 8'h00;
                    osc_tick_r <= 1'b1;
                end else begin
                    odiv_r <= odiv_r + 8'h01;
                end
            end
        end
    end

    wire old_tick = act_sel_r ? osc_tick_r : pclk_tick_r;
    wire new_tick = tgt_sel_r ? osc_tick_r : pclk_tick_r;
    // No watchdog clock reaches the prescaler while the switch settles
    wire wd_tick  = (sw_state_r == SW_IDLE) && old_tick;

    // ----------------------------------------------------------------
    // Clock source switch
    // ----------------------------------------------------------------
    // A switch towards the peripheral clock stalls in power down, so software
    // must leave two old and two new ticks after the feed before it sleeps.
    always @(posedge clk) begin
        if (rst) begin
            sw_state_r <= SW_IDLE;
            sw_cnt_r   <= 2'd0;
            act_sel_r  <= CTRL_RST[`WDF_CLKSEL_BIT];
            tgt_sel_r  <= CTRL_RST[`WDF_CLKSEL_BIT];
        end else begin
            case (sw_state_r)
                SW_IDLE: begin
                    if (feed_done && (clock_source_select_r != act_sel_r)) begin
                        tgt_sel_r  <= clock_source_select_r;
                        sw_cnt_r   <= 2'd0;
                        sw_state_r <= SW_DROP;
                    end
                end
                SW_DROP: begin
                    if (old_tick) begin
                        if (sw_cnt_r == `WDF_SYNC_TICKS - 1) begin
                            sw_cnt_r   <= 2'd0;
                            sw_state_r <= SW_ADD;
                        end else begin
                            sw_cnt_r <= sw_cnt_r + 2'd1;
                        end
                    end
                end
                SW_ADD: begin
                    if (new_tick) begin
                        if (sw_cnt_r == `WDF_SYNC_TICKS - 1) begin
                            act_sel_r  <= tgt_sel_r;
                            sw_state_r <= SW_IDLE;
                        end else begin
                            sw_cnt_r <= sw_cnt_r + 2'd1;
                        end
                    end
                end
                default: begin
                    sw_state_r <= SW_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Active control (shadow) register
    // ----------------------------------------------------------------
    // Timer mode samples every cpu clock but lands on the next watchdog clock.
    // Watchdog mode changes the shadow only through a completed feed.
    always @(posedge clk) begin
        if (rst) begin
            sh_tap_r   <= CTRL_RST[`WDF_TAP_HI:`WDF_TAP_LO];
            sh_run_r   <= CTRL_RST[`WDF_RUN_BIT];
            pend_upd_r <= 1'b0;
        end else if (feed_done) begin
            sh_tap_r   <= tap_select_r;
            sh_run_r   <= run_bit_r;
            pend_upd_r <= 1'b0;
        end else if (!wd_mode) begin
            if ((sh_tap_r != tap_select_r) || (sh_run_r != run_bit_r)) begin
                pend_upd_r <= 1'b1;
            end
            if (pend_upd_r && wd_tick) begin
                sh_tap_r   <= tap_select_r;
                sh_run_r   <= run_bit_r;
                pend_upd_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Prescaler and down counter
    // ----------------------------------------------------------------
    // Tap n wraps the prescaler every 2^(5+n) watchdog clocks.
    // A source switch shifts the first count by up to four ticks.
    // Underflow needs a watchdog tick, so a stopped clock never times out.
    wire [`WDF_PRESC_W-1:0] tap_mask =
        ({{(`WDF_PRESC_W-1){1'b0}}, 1'b1} << (`WDF_TAP_BASE + sh_tap_r)) - 1'b1;
    wire presc_wrap = (presc_r == tap_mask);
    wire underflow  = wd_tick && sh_run_r && expire_r;

    always @(posedge clk) begin
        if (rst) begin
            presc_r  <= {`WDF_PRESC_W{1'b0}};
            count_r  <= `WDF_RELOAD_RST;
            expire_r <= 1'b0;
        end else if (feed_done) begin
            presc_r  <= {`WDF_PRESC_W{1'b0}};
            count_r  <= reload_value_r;
            expire_r <= 1'b0;
        end else if (underflow) begin
            presc_r  <= {`WDF_PRESC_W{1'b0}};
            count_r  <= reload_value_r;
            expire_r <= 1'b0;
        end else if (wd_tick && sh_run_r) begin
            if (presc_wrap) begin
                presc_r <= {`WDF_PRESC_W{1'b0}};
                if (count_r == 8'h00) begin
                    // The extra clock of the timeout is spent here
                    expire_r <= 1'b1;
                end else begin
                    count_r <= count_r - 8'h01;
                end
            end else begin
                presc_r <= presc_r + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Reset and interrupt outputs
    // ----------------------------------------------------------------
    // Reset is held until the next watchdog clock, so it spans at least one.
    // The block never resets itself; the system returns this request to rst.
    always @(posedge clk) begin
        if (rst) begin
            wdt_reset_out <= 1'b0;
            wdt_irq       <= 1'b0;
        end else begin
            if (wd_mode && (underflow || feed_bad)) begin
                wdt_reset_out <= 1'b1;
            end else if (wd_tick) begin
                wdt_reset_out <= 1'b0;
            end
            wdt_irq <= !wd_mode && watchdog_irq_enable
                       && (underflow_flag_r || underflow);
        end
    end

    // ----------------------------------------------------------------
    // Software-visible registers
    // ----------------------------------------------------------------
    // A malformed feed in timer mode simply falls through with no effect.
    always @(posedge clk) begin
        if (rst) begin
            tap_select_r          <= CTRL_RST[`WDF_TAP_HI:`WDF_TAP_LO];
            run_bit_r             <= CTRL_RST[`WDF_RUN_BIT];
            clock_source_select_r <= CTRL_RST[`WDF_CLKSEL_BIT];
            underflow_flag_r      <= 1'b0;
            reload_value_r        <= `WDF_RELOAD_RST;
        end else begin
            if (wr_ctrl) begin
                tap_select_r          <= sfr_wdata[`WDF_TAP_HI:`WDF_TAP_LO];
                run_bit_r             <= sfr_wdata[`WDF_RUN_BIT];
                clock_source_select_r <= sfr_wdata[`WDF_CLKSEL_BIT];
            end
            if (wr_reload) begin
                reload_value_r <= sfr_wdata;
            end
            // Set beats a simultaneous software clear
            // Writing one to the flag leaves it as it is
            if (!wd_mode && underflow) begin
                underflow_flag_r <= 1'b1;
            end else if (wr_ctrl && !sfr_wdata[`WDF_FLAG_BIT]) begin
                underflow_flag_r <= 1'b0;
            end
        end
    end

    // Feed registers and unmapped addresses read back as zero
    always @* begin
        rdata_nxt = 8'h00;
        if (sfr_addr == `WDF_ADDR_CTRL) begin
            rdata_nxt = {tap_select_r, 2'b00, run_bit_r,
                         underflow_flag_r, clock_source_select_r};
        end else if (sfr_addr == `WDF_ADDR_RELOAD) begin
            rdata_nxt = reload_value_r;
        end
    end

    // Read data stands until the next read strobe
    always @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_re) begin
            sfr_rdata <= rdata_nxt;
        end
    end

endmodule // wdf_watchdog

/* pkg/wdf_defines.vh */
`ifndef WDF_DEFINES_VH
`define WDF_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses on the special function register bus
// ----------------------------------------------------------------
`define WDF_ADDR_CTRL      8'ha7
`define WDF_ADDR_RELOAD    8'hc1
`define WDF_ADDR_FEED1     8'hc2
`define WDF_ADDR_FEED2     8'hc3

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define WDF_TAP_HI         7
`define WDF_TAP_LO         5
`define WDF_RUN_BIT        2
`define WDF_FLAG_BIT       1
`define WDF_CLKSEL_BIT     0

// ----------------------------------------------------------------
// Reset values and feed codes
// ----------------------------------------------------------------
`define WDF_CTRL_RST       8'he5
`define WDF_RELOAD_RST     8'hff
`define WDF_FEED1_CODE     8'ha5
`define WDF_FEED2_CODE     8'h5a

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDF_CLK_HZ         40000000
`define WDF_OSC_HZ         400000
`define WDF_OSC_DIV        (`WDF_CLK_HZ / `WDF_OSC_HZ)
`define WDF_PCLK_DIV       2
`define WDF_SYNC_TICKS     2
`define WDF_PRESC_W        13
`define WDF_TAP_BASE       5

`endif

/* test/wdf_watchdog_properties.sv */
`timescale 1ns/1ps
`include "wdf_defines.vh"

module wdf_watchdog_properties #(
    parameter OSC_DIV  = 4,
    parameter PCLK_DIV = 2
) (
    // Clock and reset
    input wire       clk,
    input wire       rst,
    // Register bus
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_we,
    input wire       sfr_re,
    input wire [7:0] sfr_rdata,
    // Configuration and results
    input wire       reset_enable_cfg,
    input wire       watchdog_irq_enable,
    input wire       power_down,
    input wire       wdt_reset_out,
    input wire       wdt_irq,
    input wire       osc_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Interrupt and reset outputs
    // ----------------------------------------------------------------
    chk_irq_needs_en: assert property (
        wdt_irq |-> $past(watchdog_irq_enable) && !$past(reset_enable_cfg))
        else $error("irq without enable in timer mode");
    chk_irq_drops: assert property (
        !watchdog_irq_enable |=> !wdt_irq)
        else $error("irq stays after enable dropped");
    chk_bad_feed_rst: assert property (
        sfr_we && sfr_addr == `WDF_ADDR_FEED2 && sfr_wdata != `WDF_FEED2_CODE
        && reset_enable_cfg |-> ##[1:2] wdt_reset_out)
        else $error("bad feed gave no reset");
    chk_timer_no_rst: assert property (
        $rose(wdt_reset_out) |-> $past(reset_enable_cfg))
        else $error("reset raised in timer mode");
    // An idle cycle may sit between the two feed writes, reads too
    chk_good_feed_safe: assert property (
        (sfr_we && sfr_addr == `WDF_ADDR_FEED1 && sfr_wdata == `WDF_FEED1_CODE)
        ##1 !sfr_we ##1 (sfr_we && sfr_addr == `WDF_ADDR_FEED2
        && sfr_wdata == `WDF_FEED2_CODE) |=> !$rose(wdt_reset_out))
        else $error("good feed raised reset");

    // ----------------------------------------------------------------
    // Control register reads and oscillator
    // ----------------------------------------------------------------
    chk_reserved_zero: assert property (
        $past(sfr_re) && $past(sfr_addr) == `WDF_ADDR_CTRL |-> sfr_rdata[4:3] == 2'b00)
        else $error("reserved control bits read nonzero");
    chk_tap_readback: assert property (
        (sfr_we && sfr_addr == `WDF_ADDR_CTRL) ##1 !sfr_we ##1
        (sfr_re && sfr_addr == `WDF_ADDR_CTRL) |=> sfr_rdata[7:5] == $past(sfr_wdata[7:5], 3))
        else $error("tap field readback differs");
    chk_osc_awake: assert property (
        !$past(power_down) |-> osc_running)
        else $error("oscillator stopped outside power down");
endmodule // wdf_watchdog_properties

bind wdf_watchdog wdf_watchdog_properties #(.OSC_DIV(OSC_DIV), .PCLK_DIV(PCLK_DIV)) u_props (.*);

/* test/wdf_watchdog_tb.sv */
`timescale 1ns/1ps
`include "wdf_defines.vh"

module wdf_watchdog_tb;
    localparam int D = 4;
    reg        clk = 0, rst = 1, sfr_we = 0, sfr_re = 0;
    reg  [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rl;
    reg        reset_enable_cfg = 0, watchdog_irq_enable = 0, power_down = 0;
    reg  [2:0] tap;
    wire [7:0] sfr_rdata;
    wire       wdt_reset_out, wdt_irq, osc_running;
    integer    error_cnt = 0, n_compared = 0, i, cnt, t;

    always #12.5 clk = ~clk;

    wdf_watchdog #(.OSC_DIV(D), .PCLK_DIV(2)) u_wdf_watchdog (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
        .reset_enable_cfg(reset_enable_cfg), .watchdog_irq_enable(watchdog_irq_enable),
        .power_down(power_down), .wdt_reset_out(wdt_reset_out), .wdt_irq(wdt_irq),
        .osc_running(osc_running));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task give_verdict;
        begin
            $display("errors %0d compared %0d", error_cnt, n_compared);
            if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task fail(input string what);
        begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task cmp_byte(input [7:0] got, input [7:0] exp, input string what);
        begin
            n_compared++;
            if (got !== exp) fail(what);
        end
    endtask
    task cmp_bit(input got, input exp, input string what);
        begin
            n_compared++;
            if (got !== exp) fail(what);
        end
    endtask
    // One access, then an idle cycle so no strobe is driven twice in a step
    task bus(input w, input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            sfr_we = w; sfr_re = !w; sfr_addr = a; sfr_wdata = d;
            @(negedge clk);
            sfr_we = 0; sfr_re = 0;
        end
    endtask
    task feed;
        begin
            bus(1, `WDF_ADDR_FEED1, `WDF_FEED1_CODE);
            bus(1, `WDF_ADDR_FEED2, `WDF_FEED2_CODE);
        end
    endtask
    function integer exp_ticks(input [2:0] p, input [7:0] w);
        exp_ticks = (1 << (5 + p)) * (w + 1) + 1;
    endfunction
    // Irq needs two edges to fall after a clear, so it is skipped first
    task wait_ev(input sel, input integer lo, input integer hi);
        begin
            cnt = 0;
            if (!sel) begin repeat (2) @(negedge clk); cnt = 2; end
            while (((sel ? wdt_reset_out : wdt_irq) !== 1'b1) && cnt <= hi) begin
                @(negedge clk);
                cnt++;
            end
            n_compared++;
            if (cnt > hi) begin fail("event never came"); give_verdict; end
            else if (cnt < lo) fail("event too early");
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        #1500000;
        fail("run hung");
        give_verdict;
    end

    initial begin
        i = $urandom(44);
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 0;
        bus(0, `WDF_ADDR_CTRL, 8'h00);
        cmp_byte(sfr_rdata, `WDF_CTRL_RST, "control reset");
        bus(0, `WDF_ADDR_RELOAD, 8'h00);
        cmp_byte(sfr_rdata, `WDF_RELOAD_RST, "reload reset");
        bus(0, 8'h00, 8'h00);
        cmp_byte(sfr_rdata, 8'h00, "unmapped read");
        watchdog_irq_enable = 1;
        for (i = 0; i < 4; i++) begin
            tap = (i == 0) ? 3'h0 : $urandom % 2;
            rl = (i == 0) ? 8'h00 : $urandom % 4;
            t = exp_ticks(tap, rl);
            bus(1, `WDF_ADDR_CTRL, {tap, 5'b00101});
            bus(1, `WDF_ADDR_FEED2, 8'h00);
            cmp_bit(wdt_reset_out, 1'b0, "timer bad feed reset");
            bus(1, `WDF_ADDR_RELOAD, rl);
            feed;
            wait_ev(0, (t - 1) * D, (t + 3) * D + 8);
            bus(0, `WDF_ADDR_CTRL, 8'h00);
            cmp_byte(sfr_rdata, {tap, 5'b00111}, "flag after underflow");
            bus(1, `WDF_ADDR_CTRL, {tap, 5'b00101});
            wait_ev(0, (t - 1) * D - 16, (t + 1) * D);
        end
        watchdog_irq_enable = 0;
        bus(1, `WDF_ADDR_CTRL, 8'h05);
        bus(0, `WDF_ADDR_CTRL, 8'h00);
        cmp_byte(sfr_rdata, 8'h05, "flag cleared");
        cmp_bit(wdt_irq, 1'b0, "irq masked");
        bus(1, `WDF_ADDR_CTRL, 8'h04);
        bus(1, `WDF_ADDR_RELOAD, 8'h00);
        feed;
        repeat (20) @(negedge clk);
        power_down = 1;
        repeat (3) @(negedge clk);
        cmp_bit(osc_running, 1'b0, "oscillator in power down");
        repeat (300) @(negedge clk);
        bus(0, `WDF_ADDR_CTRL, 8'h00);
        cmp_byte(sfr_rdata, 8'h04, "halted in power down");
        power_down = 0;
        repeat (100) @(negedge clk);
        bus(0, `WDF_ADDR_CTRL, 8'h00);
        cmp_byte(sfr_rdata, 8'h06, "peripheral clock timeout");
        // Timer mode must stop the counter without any feed
        bus(1, `WDF_ADDR_CTRL, 8'h00);
        repeat (200) @(negedge clk);
        bus(0, `WDF_ADDR_CTRL, 8'h00);
        cmp_byte(sfr_rdata, 8'h00, "stopped without feed");
        reset_enable_cfg = 1;
        bus(1, `WDF_ADDR_FEED2, 8'h00);
        wait_ev(1, 0, 3);
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        bus(1, `WDF_ADDR_RELOAD, 8'h00);
        bus(1, `WDF_ADDR_CTRL, 8'h05);
        feed;
        t = exp_ticks(3'h0, 8'h00);
        wait_ev(1, (t - 1) * D, (t + 3) * D + 8);
        give_verdict;
    end
endmodule // wdf_watchdog_tb
